// [verilog/psa_arith_unit.sv]
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [RULE_01] add and subtract set the zero flag when the exact result is zero
// [RULE_02] borrow flag set when result is below -32768 or -2147483648
// [RULE_03] carry flag set when result is above 32767 or 2147483647
// [RULE_04] add writes first source plus second source to the destination
// [RULE_05] subtract writes first source minus second source to the destination
// [RULE_06] all operands are signed two's complement, msb one means negative
// [RULE_07] subtract updates the three flags exactly as add does
// [RULE_08] 32-bit values span two words, low half in the lower word
// [RULE_09] 16-bit multiply gives signed 32-bit product, low word first
// [RULE_10] 32-bit multiply gives signed 64-bit product over four words
// [RULE_11] multiply honours operand signs; product msb shows result sign
// [RULE_12] zero divisor: no divide, set error flags, record code 0E19
// [RULE_13] 16-bit divide puts quotient first, then remainder in next word
// [RULE_14] 32-bit divide puts quotient in two words, remainder in next two
// [RULE_15] grouped bit destination takes 1-4 or 1-8 nibbles of low result only
// [RULE_16] increment and decrement wrap at the limits and leave flags alone
// [RULE_17] divide fault raises program error and latched error with cause code
// [RULE_18] overflowed add or subtract stores the result truncated to width
// [RULE_19] each add or subtract clears any flag whose condition is not met
module psa_arith_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   // instruction request from the sequencer
   input wire logic op_valid_i,
   output logic op_ready_o,
   input wire psa_pkg::psa_op_t op_code_i,
   input wire logic op_wide_i,
   input wire logic [31:0] src1_i,
   input wire logic [31:0] src2_i,
   input wire logic [3:0] dst_nibbles_i,
   // result toward device memory
   output logic res_valid_o,
   output logic [63:0] res_data_o,
   output logic [2:0] res_words_o,
   // special flag devices
   output logic result_zero_flag_o,
   output logic borrow_flag_o,
   output logic carry_flag_o,
   output logic program_error_flag_o,
   output logic error_latched_flag_o,
   output logic [15:0] error_code_word_o,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import psa_pkg::*;

   typedef enum logic {
      PSA_IDLE,
      PSA_DIV_WAIT
   } psa_state_t;

   psa_state_t state_q, state_d;
   logic res_valid_q;
   logic [63:0] res_data_q;
   logic [2:0] res_words_q;
   logic zero_q, borrow_q, carry_q, perr_q, elatch_q;
   logic [15:0] ecode_q;
   logic wide_q, nib_div_q;
   logic [3:0] nib_q;
   logic ack_q;
   logic [31:0] rdata_q;

   // operands sign-extended to 32 bits so one datapath serves both widths
   wire [31:0] a32 = op_wide_i ? src1_i : {{16{src1_i[15]}}, src1_i[15:0]}; // RULE_06
   wire [31:0] b32 = op_wide_i ? src2_i : {{16{src2_i[15]}}, src2_i[15:0]}; // RULE_06
   wire take = op_valid_i && op_ready_o;
   wire is_sub = (op_code_i == PSA_OP_SUB);

   // exact 33-bit result; no 16- or 32-bit value can overflow it
   wire [32:0] addend = is_sub ? 33'(-{b32[31], b32}) : {b32[31], b32}; // RULE_05
   wire [32:0] sum33 = {a32[31], a32} + addend; // RULE_04
   wire sum_zero = (sum33 == 33'h0_0000_0000); // RULE_01
   // out of range above 32767 / 2147483647 and below -32768 / -2147483648
   wire hi16_all0 = (sum33[31:15] == 17'h0_0000);
   wire hi16_all1 = (sum33[31:15] == 17'h1_FFFF);
   wire sum_carry = op_wide_i ? (~sum33[32] & sum33[31]) : (~sum33[32] & ~hi16_all0); // RULE_03
   wire sum_borrow = op_wide_i ? (sum33[32] & ~sum33[31]) : (sum33[32] & ~hi16_all1); // RULE_02
   // truncated two's complement goes to the destination even on overflow
   wire [63:0] sum_res = op_wide_i ? {32'h0000_0000, sum33[31:0]}
                                   : {48'h0000_0000_0000, sum33[15:0]}; // RULE_18

   // signed product; 16-bit operands already sign-extended
   wire [63:0] prod = 64'($signed(a32) * $signed(b32)); // RULE_11
   wire [63:0] mul_res = op_wide_i ? prod : {32'h0000_0000, prod[31:0]}; // RULE_09 RULE_10

   // increment and decrement simply wrap at the width
   wire [31:0] step32 = (op_code_i == PSA_OP_DEC) ? 32'(a32 - 32'h0000_0001)
                                                  : 32'(a32 + 32'h0000_0001);
   wire [63:0] step_res = op_wide_i ? {32'h0000_0000, step32}
                                    : {48'h0000_0000_0000, step32[15:0]}; // RULE_16

   // zero divisor is judged at the operation width
   wire div_zero = op_wide_i ? (src2_i == 32'h0000_0000)
                             : (src2_i[15:0] == 16'h0000); // RULE_12
   wire div_start = take && (op_code_i == PSA_OP_DIV) && !div_zero;
   wire div_busy, div_done;
   wire [31:0] div_quot, div_rem;

   psa_divider #(
      .W(32)
   ) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(div_start),
      .dividend_i(a32),
      .divisor_i(b32),
      .busy_o(div_busy),
      .done_o(div_done),
      .quot_o(div_quot),
      .rem_o(div_rem)
   );

   // quotient first, remainder in the following word(s)
   wire [63:0] div_res = wide_q ? {div_rem, div_quot}
                                : {32'h0000_0000, div_rem[15:0], div_quot[15:0]}; // RULE_13 RULE_14

   // grouped bit destination: clamp the group count, keep only its nibbles
   wire [3:0] nib_max = op_wide_i ? PSA_NIB_MAX32 : PSA_NIB_MAX16;
   wire [3:0] nib_now = (dst_nibbles_i > nib_max) ? nib_max : dst_nibbles_i; // RULE_15
   wire [3:0] nib_sel = (state_q == PSA_DIV_WAIT) ? nib_q : nib_now;
   wire [63:0] nib_mask = 64'((64'h0000_0000_0000_0001 << {nib_sel, 2'b00}) - 64'h1);
   wire [2:0] nib_words = 3'(({1'b0, nib_sel} + 5'h3) >> 2);

   // result selection for the single-cycle operations
   logic [63:0] fast_res;
   logic [2:0] fast_words;
   always_comb begin
      fast_res = sum_res;
      fast_words = op_wide_i ? 3'h2 : 3'h1; // RULE_08
      case (op_code_i)
         PSA_OP_MUL: begin
            fast_res = mul_res;
            fast_words = op_wide_i ? 3'h4 : 3'h2; // RULE_09 RULE_10
            if (nib_now != 4'h0) begin
               fast_res = mul_res & nib_mask; // RULE_15
               fast_words = nib_words;
            end
         end
         PSA_OP_INC, PSA_OP_DEC: begin
            fast_res = step_res;
         end
         default: begin
            fast_res = sum_res;
         end
      endcase
   end

   // divide result packing, including a grouped bit destination
   wire [63:0] div_out = nib_div_q ? (div_res & nib_mask) : div_res;
   wire [2:0] div_words = nib_div_q ? nib_words : (wide_q ? 3'h4 : 3'h2);

   // sequencer: only a divide needs more than one cycle
   always_comb begin
      state_d = state_q;
      case (state_q)
         PSA_IDLE: begin
            if (div_start) begin
               state_d = PSA_DIV_WAIT;
            end
         end
         PSA_DIV_WAIT: begin
            if (div_done) begin
               state_d = PSA_IDLE;
            end
         end
         default: begin
            state_d = PSA_IDLE;
         end
      endcase
   end
   assign op_ready_o = (state_q == PSA_IDLE) && !div_busy;

   // result register: one-cycle valid pulse with words to store
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= PSA_IDLE;
         res_valid_q <= 1'b0;
         res_data_q <= 64'h0000_0000_0000_0000;
         res_words_q <= 3'h0;
         wide_q <= 1'b0;
         nib_q <= 4'h0;
         nib_div_q <= 1'b0;
      end else begin
         state_q <= state_d;
         res_valid_q <= 1'b0;
         if (take && op_code_i != PSA_OP_DIV) begin
            res_valid_q <= 1'b1;
            res_data_q <= fast_res;
            res_words_q <= fast_words;
         end else if (take && div_zero) begin
            res_valid_q <= 1'b1; // zero words: destination untouched RULE_12
            res_words_q <= 3'h0;
         end else if (div_done) begin
            res_valid_q <= 1'b1;
            res_data_q <= div_out;
            res_words_q <= div_words;
         end
         if (div_start) begin
            wide_q <= op_wide_i;
            nib_q <= nib_now;
            nib_div_q <= (nib_now != 4'h0);
         end
      end
   end

   // add/sub rewrites all three flags; other operations leave them alone
   wire arith_take = take && (op_code_i == PSA_OP_ADD || is_sub); // RULE_07 RULE_16
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         zero_q <= 1'b0;
         borrow_q <= 1'b0;
         carry_q <= 1'b0;
      end else if (arith_take) begin
         zero_q <= sum_zero; // RULE_19
         borrow_q <= sum_borrow; // RULE_19
         carry_q <= sum_carry; // RULE_19
      end
   end

   // wishbone decode; control writes are single-cycle pulses on the ack edge
   wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
   wire hit_status = (wb_adr_i == PSA_REG_STATUS);
   wire hit_code = (wb_adr_i == PSA_REG_ERRCODE);
   wire hit_ctrl = (wb_adr_i == PSA_REG_CONTROL);
   // commit on the edge that sees ack high, while the master still holds the request
   wire ctrl_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && hit_ctrl && wb_sel_i[0];
   wire clr_perr = ctrl_wr && wb_dat_i[PSA_CT_CLR_PERR];
   wire clr_elatch = ctrl_wr && wb_dat_i[PSA_CT_CLR_ELATCH];
   wire clr_code = ctrl_wr && wb_dat_i[PSA_CT_CLR_CODE];
   wire fault = take && (op_code_i == PSA_OP_DIV) && div_zero;

   // error flags: a fault in the same cycle as a clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         perr_q <= 1'b0;
         elatch_q <= 1'b0;
         ecode_q <= PSA_ERR_NONE;
      end else begin
         if (fault) begin
            perr_q <= 1'b1; // RULE_12 RULE_17
            elatch_q <= 1'b1; // RULE_17
            ecode_q <= PSA_ERR_DIV_ZERO; // RULE_12
         end else begin
            if (clr_perr) begin
               perr_q <= 1'b0;
            end
            if (clr_elatch) begin
               elatch_q <= 1'b0;
            end
            if (clr_code) begin
               ecode_q <= PSA_ERR_NONE;
            end
         end
      end
   end

   // status image; unmapped addresses read zero and are still acked
   wire [31:0] status_word = {26'h000_0000, !op_ready_o, elatch_q, perr_q,
                              carry_q, borrow_q, zero_q};
   wire [31:0] rd_mux = hit_status ? status_word :
                        hit_code ? {16'h0000, ecode_q} : 32'h0000_0000;

   // ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_req;
         if (wb_req && !wb_we_i) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign res_valid_o = res_valid_q;
   assign res_data_o = res_data_q;
   assign res_words_o = res_words_q;
   assign result_zero_flag_o = zero_q;
   assign borrow_flag_o = borrow_q;
   assign carry_flag_o = carry_q;
   assign program_error_flag_o = perr_q;
   assign error_latched_flag_o = elatch_q;
   assign error_code_word_o = ecode_q;
endmodule

`default_nettype wire

// [verilog/psa_pkg.sv]
package psa_pkg;

   // operation codes presented by the instruction sequencer
   typedef enum logic [2:0] {
      PSA_OP_ADD,
      PSA_OP_SUB,
      PSA_OP_MUL,
      PSA_OP_DIV,
      PSA_OP_INC,
      PSA_OP_DEC
   } psa_op_t;

   // error code recorded when a divide meets a zero divisor
   localparam logic [15:0] PSA_ERR_DIV_ZERO = 16'h0E19;
   localparam logic [15:0] PSA_ERR_NONE = 16'h0000;

   // register byte offsets on the wishbone slave
   localparam logic [3:0] PSA_REG_STATUS = 4'h0;
   localparam logic [3:0] PSA_REG_ERRCODE = 4'h4;
   localparam logic [3:0] PSA_REG_CONTROL = 4'h8;

   // status register bit positions
   localparam int PSA_ST_ZERO = 0;
   localparam int PSA_ST_BORROW = 1;
   localparam int PSA_ST_CARRY = 2;
   localparam int PSA_ST_PERR = 3;
   localparam int PSA_ST_ELATCH = 4;
   localparam int PSA_ST_BUSY = 5;

   // control register bit positions (write one to act)
   localparam int PSA_CT_CLR_PERR = 0;
   localparam int PSA_CT_CLR_ELATCH = 1;
   localparam int PSA_CT_CLR_CODE = 2;

   // nibble group limits for grouped bit destinations
   localparam logic [3:0] PSA_NIB_MAX16 = 4'h4;
   localparam logic [3:0] PSA_NIB_MAX32 = 4'h8;

endpackage

// [verilog/psa_divider.sv]
`timescale 1ns/1ns
`default_nettype none

// signed restoring divider: quotient truncates toward zero, remainder takes the
// dividend's sign; one quotient bit per cycle, so W cycles after start
module psa_divider #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [W-1:0] dividend_i,
   input wire logic [W-1:0] divisor_i,
   output logic busy_o,
   output logic done_o,
   output logic [W-1:0] quot_o,
   output logic [W-1:0] rem_o
);
   import psa_pkg::*;

   logic [W-1:0] q_q, r_q, d_q;
   logic [$clog2(W+1)-1:0] cnt_q;
   logic neg_q_q, neg_r_q, done_q;
   wire [W-1:0] dvd_mag = dividend_i[W-1] ? W'(-dividend_i) : dividend_i;
   wire [W-1:0] dvs_mag = divisor_i[W-1] ? W'(-divisor_i) : divisor_i;
   wire [W:0] shifted = {r_q, q_q[W-1]};
   wire [W:0] trial = shifted - {1'b0, d_q};
   wire fits = ~trial[W];

   // one shift-subtract step per cycle while the count runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_q <= '0;
         r_q <= '0;
         d_q <= '0;
         cnt_q <= '0;
         neg_q_q <= 1'b0;
         neg_r_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start_i && cnt_q == '0) begin
            q_q <= dvd_mag;
            r_q <= '0;
            d_q <= dvs_mag;
            cnt_q <= ($clog2(W+1))'(W);
            neg_q_q <= dividend_i[W-1] ^ divisor_i[W-1];
            neg_r_q <= dividend_i[W-1];
         end else if (cnt_q != '0) begin
            r_q <= fits ? trial[W-1:0] : shifted[W-1:0];
            q_q <= {q_q[W-2:0], fits};
            cnt_q <= cnt_q - 1'b1;
            done_q <= (cnt_q == ($clog2(W+1))'(1));
         end
      end
   end

   // signs restored from flops; held stable until the next start
   assign quot_o = neg_q_q ? W'(-q_q) : q_q;
   assign rem_o = neg_r_q ? W'(-r_q) : r_q;
   assign busy_o = (cnt_q != '0);
   assign done_o = done_q;
endmodule

`default_nettype wire

// [testbench/psa_arith_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module psa_arith_assertions
   import psa_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input wire logic op_ready_o,
   input wire psa_pkg::psa_op_t op_code_i,
   input wire logic op_wide_i,
   input wire logic [31:0] src1_i,
   input wire logic [31:0] src2_i,
   input wire logic res_valid_o,
   input wire logic [2:0] res_words_o,
   input wire logic result_zero_flag_o,
   input wire logic borrow_flag_o,
   input wire logic carry_flag_o,
   input wire logic program_error_flag_o,
   input wire logic error_latched_flag_o,
   input wire logic [15:0] error_code_word_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // taken request, zero divisor at op width, exact 16-bit sum
   wire logic tk = op_valid_i && op_ready_o;
   wire logic dz = op_wide_i ? (src2_i == 32'h0) : (src2_i[15:0] == 16'h0);
   wire logic dv = tk && op_code_i == PSA_OP_DIV;
   wire logic signed [16:0] s16 = $signed(src1_i[15:0]) + $signed(src2_i[15:0]);
   a_take_answer: assert property (tk && op_code_i != PSA_OP_DIV |=> res_valid_o)
      else $error("no result one cycle after take");
   a_div_fault: assert property (dv && dz |=> res_valid_o && res_words_o == 3'h0
      && program_error_flag_o && error_latched_flag_o && error_code_word_o == PSA_ERR_DIV_ZERO)
      else $error("zero divisor not flagged");
   a_div_busy: assert property (dv && !dz |=> !op_ready_o [*8])
      else $error("ready during divide");
   a_div_done: assert property (dv && !dz |-> ##34 res_valid_o)
      else $error("divide result late");
   a_add16_flags: assert property (tk && op_code_i == PSA_OP_ADD && !op_wide_i |=>
      carry_flag_o == ($past(s16) > 17'sh07FFF) && borrow_flag_o == ($past(s16) < -17'sh08000)
      && result_zero_flag_o == ($past(s16) == 17'sh00000))
      else $error("add flags wrong");
   a_flags_kept: assert property (tk && (op_code_i inside {PSA_OP_MUL, PSA_OP_INC,
      PSA_OP_DEC}) |=> $stable({result_zero_flag_o, borrow_flag_o, carry_flag_o}))
      else $error("flags moved");
   a_words_add: assert property (tk && (op_code_i inside {PSA_OP_ADD, PSA_OP_SUB}) |=>
      res_words_o == ($past(op_wide_i) ? 3'h2 : 3'h1))
      else $error("add word count wrong");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held");
endmodule
bind psa_arith_unit psa_arith_assertions u_chk (.clk_i, .rst_i, .op_valid_i, .op_ready_o,
   .op_code_i, .op_wide_i, .src1_i, .src2_i, .res_valid_o, .res_words_o, .result_zero_flag_o,
   .borrow_flag_o, .carry_flag_o, .program_error_flag_o, .error_latched_flag_o,
   .error_code_word_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// [testbench/psa_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module psa_mem_model (
   input wire logic clk_i,
   input wire logic res_valid_i,
   input wire logic [63:0] res_data_i,
   input wire logic [2:0] res_words_i,
   output logic [63:0] mem_o
);
   // word memory from dst on; uncounted words keep older contents
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (res_valid_i && i < res_words_i) begin
            mem_o[16*i +: 16] <= res_data_i[16*i +: 16];
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/plc_signed_arith_unit_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module plc_signed_arith_unit_tb;
   import psa_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic op_valid_i = 1'b0;
   psa_op_t op_code_i = PSA_OP_ADD;
   logic op_wide_i = 1'b0;
   logic [31:0] src1_i = 32'h0;
   logic [31:0] src2_i = 32'h0;
   logic [3:0] dst_nibbles_i = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic op_ready_o, res_valid_o, result_zero_flag_o, borrow_flag_o, carry_flag_o;
   logic program_error_flag_o, error_latched_flag_o, wb_ack_o;
   logic [63:0] res_data_o, mem;
   logic [2:0] res_words_o;
   logic [15:0] error_code_word_o;
   logic [31:0] wb_dat_o;
   logic [2:0] ef = 3'h0;
   logic [133:0] q[$];
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   psa_arith_unit u_dut (.clk_i, .rst_i, .op_valid_i, .op_ready_o, .op_code_i, .op_wide_i,
      .src1_i, .src2_i, .dst_nibbles_i, .res_valid_o, .res_data_o, .res_words_o,
      .result_zero_flag_o, .borrow_flag_o, .carry_flag_o, .program_error_flag_o,
      .error_latched_flag_o, .error_code_word_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   psa_mem_model u_mem (.clk_i, .res_valid_i(res_valid_o), .res_data_i(res_data_o),
      .res_words_i(res_words_o), .mem_o(mem));
   always #5 clk_i = ~clk_i;
   task automatic chk(string nm, logic [127:0] s, logic [127:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // issue one op, note its expected result; valid stays up for back to back use
   task automatic op(psa_op_t c, logic w, logic [31:0] a, logic [31:0] b, logic [3:0] n);
      longint x, y, r;
      logic [63:0] d, m;
      logic [2:0] k;
      logic [3:0] nn;
      x = w ? longint'($signed(a)) : longint'($signed(a[15:0]));
      y = w ? longint'($signed(b)) : longint'($signed(b[15:0]));
      r = (c == PSA_OP_SUB) ? x - y : x + y;
      k = w ? 3'h2 : 3'h1;
      d = 64'(r);
      if (c == PSA_OP_ADD || c == PSA_OP_SUB) ef = {r == 0, r < (w ? -64'sd2147483648 :
         -64'sd32768), r > (w ? 64'sd2147483647 : 64'sd32767)};
      if (c == PSA_OP_INC) d = 64'(x + 1);
      if (c == PSA_OP_DEC) d = 64'(x - 1);
      if (c == PSA_OP_MUL) d = 64'(x * y);
      if (c == PSA_OP_DIV && y != 0) d = w ? {32'(x % y), 32'(x / y)} : {32'h0, 16'(x % y),
         16'(x / y)};
      if (c == PSA_OP_MUL || c == PSA_OP_DIV) k = w ? 3'h4 : 3'h2;
      if (c == PSA_OP_DIV && y == 0) k = 3'h0;
      m = (64'h1 << (16 * k)) - 64'h1;
      nn = (n > (w ? PSA_NIB_MAX32 : PSA_NIB_MAX16)) ? (w ? PSA_NIB_MAX32 : PSA_NIB_MAX16) : n;
      if ((c == PSA_OP_MUL || c == PSA_OP_DIV) && k != 3'h0 && nn != 4'h0) begin
         m = (64'h1 << (4 * nn)) - 64'h1;
         k = 3'((nn + 4'h3) / 4'h4);
      end
      q.push_back({m, d & m, k, ef});
      op_valid_i <= 1'b1;
      op_code_i <= c;
      op_wide_i <= w;
      src1_i <= a;
      src2_i <= b;
      dst_nibbles_i <= n;
      do @(posedge clk_i); while (op_ready_o !== 1'b1);
   endtask
   task automatic idle();
      op_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // one classic bus cycle; reads compare the masked data
   task automatic wb(logic we, logic [3:0] ad, logic [31:0] dt, logic [31:0] m, logic [31:0] e);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= ad;
      wb_dat_i <= dt;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      if (!we) chk("bus read", wb_dat_o & m, e);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // monitor retires the oldest note on each result; also the hang limit
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         fails++;
         end_sim();
      end else if (res_valid_o === 1'b1 && q.size() == 0) begin
         chk("extra result", 1, 0);
      end else if (res_valid_o === 1'b1) begin
         chk("data", res_data_o & q[0][133:70], q[0][69:6]);
         chk("words", res_words_o, q[0][5:3]);
         chk("flags", {result_zero_flag_o, borrow_flag_o, carry_flag_o}, q[0][2:0]);
         void'(q.pop_front());
      end
   end
   initial begin
      void'($urandom(55502));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, PSA_REG_STATUS, 32'h0, 32'h3F, 32'h0);
      wb(1'b0, 4'hC, 32'h0, 32'hFFFFFFFF, 32'h0);
      op(PSA_OP_ADD, 1'b0, 32'h7FFF, 32'h1, 4'h0);
      op(PSA_OP_ADD, 1'b0, 32'h8000, 32'hFFFF, 4'h0);
      op(PSA_OP_SUB, 1'b0, 32'h5, 32'h5, 4'h0);
      op(PSA_OP_SUB, 1'b1, 32'h80000000, 32'h1, 4'h0);
      op(PSA_OP_ADD, 1'b1, 32'h7FFFFFFF, 32'h1, 4'h0);
      op(PSA_OP_ADD, 1'b1, 32'hFFFFFFFD, 32'h3, 4'h0);
      op(PSA_OP_SUB, 1'b0, 32'h7FFF, 32'hFFFF, 4'h0);
      op(PSA_OP_MUL, 1'b0, 32'hFFFD, 32'h7FFF, 4'h0);
      op(PSA_OP_MUL, 1'b1, 32'h80000000, 32'h7FFFFFFF, 4'h0);
      idle();
      @(posedge clk_i);
      chk("memory", mem, 64'hC000000080000000);
      op(PSA_OP_MUL, 1'b1, 32'hFFFFFFFF, 32'h12345, 4'h7);
      op(PSA_OP_INC, 1'b0, 32'h7FFF, 32'h0, 4'h0);
      op(PSA_OP_DEC, 1'b1, 32'h80000000, 32'h0, 4'h0);
      op(PSA_OP_DIV, 1'b0, 32'hFFF9, 32'h2, 4'h0);
      op(PSA_OP_DIV, 1'b1, 32'h7, 32'hFFFFFFFE, 4'h0);
      op(PSA_OP_DIV, 1'b0, 32'h1234, 32'h10, 4'hC);
      op(PSA_OP_ADD, 1'b0, 32'h1, 32'h1, 4'h0);
      for (int i = 0; i < 24; i++) begin
         op(i[0] ? PSA_OP_SUB : PSA_OP_ADD, i[1], $urandom, $urandom, 4'h0);
      end
      op(PSA_OP_DIV, 1'b0, 32'h5, 32'h10000, 4'h0);
      idle();
      chk("error", {program_error_flag_o, error_latched_flag_o, error_code_word_o},
         {2'h3, PSA_ERR_DIV_ZERO});
      wb(1'b0, PSA_REG_STATUS, 32'h0, 32'h18, 32'h18);
      wb(1'b0, PSA_REG_ERRCODE, 32'h0, 32'hFFFF, 32'h0E19);
      wb(1'b1, 4'hC, 32'h7, 32'h0, 32'h0);
      wb(1'b1, PSA_REG_CONTROL, 32'h3, 32'h0, 32'h0);
      wb(1'b0, PSA_REG_STATUS, 32'h0, 32'h18, 32'h0);
      wb(1'b1, PSA_REG_CONTROL, 32'h4, 32'h0, 32'h0);
      wb(1'b0, PSA_REG_ERRCODE, 32'h0, 32'hFFFF, 32'h0);
      chk("pending", q.size(), 0);
      end_sim();
   end
endmodule
`default_nettype wire
